// *** rtl/iam_status.sv ***
// Address-match, transmit-direction and arbitration-loss flags of the I2C unit.
// Assumes the bus front end runs on link_clk; CPU strobes arrive on clk.
//
// Contract
// - Status read or any single-bit instruction on other bits clears arbitration-lost flag.
// - Match flag set at eighth SCL rise when received address equals local address.
// - Match flag cleared by start, stop, exit write, enable fall, or reset.
// - Direction flag zero means receive and the data line stays released.
// - Direction flag one drives the output latch, from first byte's ninth falling edge.
// - Direction cleared by stop, exit, enable fall, wait release, arbitration loss, reset.
// - Master: set on start generated or driven 0 direction bit; cleared on 1.
// - Slave: set on received 1 direction bit when the address matches; cleared on start or received 0.
// - Exit bit is control bit 6, enable bit is control bit 7.
// - Wait release at ninth clock while transmitting clears direction and releases line.
module iam_status (
  // System side
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // Link sampling clock
  input  wire logic                  link_clk,
  // Bus pins
  input  wire logic                  serial_clock_line_i,
  input  wire logic                  serial_data_line_i,
  output logic                       serial_data_line_o,
  output logic                       serial_data_line_oe,
  // CPU access
  input  wire iam_pkg::iam_cpu_req_t cpu_req,
  input  wire logic [7:0]            local_slave_address_reg,
  output logic [7:0]                 bus_status_reg,
  output logic [7:0]                 bus_control_reg,
  // Neighbouring logic in the I2C unit
  input  wire logic                  master_mode,
  input  wire logic                  start_generated,
  input  wire logic                  arb_loss_evt,
  input  wire logic                  shift_output_latch
);

  // ----------------------------------------------------------------------
  // Link domain: line sampling and bit counting
  // ----------------------------------------------------------------------
  logic [1:0]        scl_sync_q;
  logic [1:0]        sda_sync_q;
  logic              scl_prev_q;
  logic              sda_prev_q;
  logic [3:0]        bit_cnt_q;
  logic [7:0]        shift_q;
  logic [7:0]        addr_byte_q;
  iam_pkg::iam_phase_t phase_q;
  iam_pkg::iam_bus_evt_t link_evt;
  iam_pkg::iam_bus_evt_t sys_evt;

  wire scl_s    = scl_sync_q[1];
  wire sda_s    = sda_sync_q[1];
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire first_byte = (phase_q == iam_pkg::PH_ADDR);
  wire [3:0] cnt_inc = 4'(bit_cnt_q + 4'h1);

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], serial_clock_line_i};
      sda_sync_q <= {sda_sync_q[0], serial_data_line_i};
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign link_evt.start_det   = scl_s & scl_prev_q & ~sda_s & sda_prev_q;
  assign link_evt.stop_det    = scl_s & scl_prev_q & sda_s & ~sda_prev_q;
  assign link_evt.eighth_rise = scl_rise & first_byte & (cnt_inc == iam_pkg::BIT_EIGHTH);
  assign link_evt.ninth_fall  = scl_fall & first_byte & (bit_cnt_q == iam_pkg::BIT_NINTH);

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q   <= iam_pkg::PH_IDLE;
      bit_cnt_q <= iam_pkg::BIT_CNT_RESET;
      shift_q   <= 8'h00;
    end else if (link_evt.start_det) begin
      phase_q   <= iam_pkg::PH_ADDR;
      bit_cnt_q <= iam_pkg::BIT_CNT_RESET;
    end else if (link_evt.stop_det) begin
      phase_q   <= iam_pkg::PH_IDLE;
      bit_cnt_q <= iam_pkg::BIT_CNT_RESET;
    end else if (phase_q != iam_pkg::PH_IDLE) begin
      if (scl_rise) begin
        bit_cnt_q <= cnt_inc;
        shift_q   <= {shift_q[6:0], sda_s};
      end else if (scl_fall && bit_cnt_q == iam_pkg::BIT_NINTH) begin
        bit_cnt_q <= iam_pkg::BIT_CNT_RESET;
        phase_q   <= iam_pkg::PH_DATA;
      end
    end
  end

  // Held until the next address byte, so the system side can read it late
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) addr_byte_q <= 8'h00;
    else if (link_evt.eighth_rise) addr_byte_q <= {shift_q[6:0], sda_s};
  end

  // ----------------------------------------------------------------------
  // Event crossing into the system clock
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < iam_pkg::NUM_EVENTS; gi++) begin : g_evt
      iam_evt_sync u_sync (
        .src_clk   (link_clk),
        .src_pulse (link_evt[gi]),
        .dst_clk   (clk),
        .dst_pulse (sys_evt[gi]),
        .rst_b     (rst_b)
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Control register and CPU strobes
  // ----------------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic       arb_lost_q;
  logic       arb_lost_d;
  logic       match_q;
  logic       match_d;
  logic       dir_q;
  logic       dir_d;
  logic       drive_q;
  logic       drive_d;
  logic       sda_oe_q;

  // One control bit written as 1 in this cycle
  function automatic logic ctrl_bit_set(input iam_pkg::iam_cpu_req_t req, input int unsigned pos);
    return req.ctrl_wr & req.ctrl_wdata[pos];
  endfunction

  wire enable_bit    = ctrl_q[iam_pkg::CTRL_ENABLE_BIT];
  wire exit_wr       = ctrl_bit_set(cpu_req, iam_pkg::CTRL_EXIT_BIT);
  wire wait_rel_wr   = ctrl_bit_set(cpu_req, iam_pkg::CTRL_WAIT_REL_BIT);
  wire enable_fall   = enable_bit & cpu_req.ctrl_wr & ~cpu_req.ctrl_wdata[iam_pkg::CTRL_ENABLE_BIT];
  // A loss while disabled still clears direction; the flag itself ignores it
  wire arb_rise      = arb_loss_evt & ~arb_lost_q;
  // The address byte has no synchroniser of its own: it is written at the link edge
  // that toggles the event, so it has long settled once the event reaches clk
  wire dir_bit       = addr_byte_q[0];
  wire addr_hit      = (addr_byte_q[7:1] == local_slave_address_reg[7:1]);

  // Exit and wait-release act as strobes and read back as zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ctrl_q <= iam_pkg::CTRL_RESET;
    else if (cpu_req.ctrl_wr) ctrl_q <= cpu_req.ctrl_wdata & 8'h9F;
  end

  // ----------------------------------------------------------------------
  // Flag next-state logic; a set wins over a clear, except that stop, exit and disable clear match and direction
  // ----------------------------------------------------------------------
  wire arb_clr   = cpu_req.status_rd | cpu_req.bit_manip | enable_fall;
  wire match_set = sys_evt.eighth_rise & addr_hit & enable_bit;
  wire match_clr = sys_evt.start_det | sys_evt.stop_det | exit_wr | enable_fall;

  wire dir_set_m = master_mode & (start_generated | (sys_evt.eighth_rise & ~dir_bit));
  wire dir_clr_m = master_mode & sys_evt.eighth_rise & dir_bit;
  wire dir_set_s = ~master_mode & sys_evt.eighth_rise & dir_bit & match_set;
  wire dir_clr_s = ~master_mode & (sys_evt.start_det | (sys_evt.eighth_rise & ~dir_bit));
  wire dir_clr_c = sys_evt.stop_det | exit_wr | enable_fall | wait_rel_wr | arb_rise;
  wire dir_set   = enable_bit & (dir_set_m | dir_set_s);
  wire dir_clr   = dir_clr_c | dir_clr_m | dir_clr_s;

  always_comb begin
    arb_lost_d = (arb_lost_q & ~arb_clr) | (arb_loss_evt & enable_bit);
    match_d    = (match_q & ~match_clr) | match_set;
    dir_d      = (dir_q & ~dir_clr) | dir_set;
    // Stop, exit and disable overrule a simultaneous set
    if (sys_evt.stop_det | exit_wr | enable_fall) begin
      match_d = 1'b0;
      dir_d   = 1'b0;
    end
    // Driving begins at the first byte's ninth falling edge
    drive_d = drive_q | (sys_evt.ninth_fall & dir_q);
    if (!dir_d) drive_d = 1'b0;
    if (wait_rel_wr) drive_d = 1'b0;
  end

  // Registered so the pin never glitches while the flags settle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arb_lost_q <= 1'b0;
      match_q    <= 1'b0;
      dir_q      <= 1'b0;
      drive_q    <= 1'b0;
      sda_oe_q   <= 1'b0;
    end else begin
      arb_lost_q <= arb_lost_d;
      match_q    <= match_d;
      dir_q      <= dir_d;
      drive_q    <= drive_d;
      sda_oe_q   <= drive_d & ~shift_output_latch;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Open-drain: only a low is ever driven; a released line is high impedance
  assign serial_data_line_o  = 1'b0;
  assign serial_data_line_oe = sda_oe_q;

  always_comb begin
    bus_status_reg = iam_pkg::STATUS_RESET;
    bus_status_reg[iam_pkg::STAT_ARB_LOST_BIT] = arb_lost_q;
    bus_status_reg[iam_pkg::STAT_MATCH_BIT]    = match_q;
    bus_status_reg[iam_pkg::STAT_DIR_BIT]      = dir_q;
  end

  assign bus_control_reg = ctrl_q;

endmodule

// *** rtl/iam_pkg.sv ***
// Constants and carrier types for the address-match and direction status block.
// Assumes a byte-wide control and status register pair on the CPU side.
package iam_pkg;

  // ----------------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_WAIT_REL_BIT = 5;
  localparam int unsigned CTRL_EXIT_BIT     = 6;
  localparam int unsigned CTRL_ENABLE_BIT   = 7;

  // ----------------------------------------------------------------------
  // Status register bit positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned STAT_ARB_LOST_BIT = 6;
  localparam int unsigned STAT_MATCH_BIT    = 4;
  localparam int unsigned STAT_DIR_BIT      = 3;
  localparam logic [7:0]  STATUS_RESET      = 8'h00;
  localparam logic [7:0]  CTRL_RESET        = 8'h00;
  localparam logic [7:0]  SLAVE_ADDR_RESET  = 8'h00;

  // ----------------------------------------------------------------------
  // Bus bit counting
  // ----------------------------------------------------------------------
  localparam logic [3:0]  BIT_CNT_RESET     = 4'h0;
  localparam logic [3:0]  BIT_EIGHTH        = 4'h8;
  localparam logic [3:0]  BIT_NINTH         = 4'h9;
  localparam int unsigned NUM_EVENTS        = 4;
  localparam int unsigned EVT_START         = 0;
  localparam int unsigned EVT_STOP          = 1;
  localparam int unsigned EVT_EIGHTH        = 2;
  localparam int unsigned EVT_NINTH         = 3;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b10
  } iam_phase_t;

  // Events seen on the bus, one bit per event kind
  typedef struct packed {
    logic ninth_fall;
    logic eighth_rise;
    logic stop_det;
    logic start_det;
  } iam_bus_evt_t;

  // CPU access strobes
  typedef struct packed {
    logic       ctrl_wr;
    logic [7:0] ctrl_wdata;
    logic       status_rd;
    logic       bit_manip;
  } iam_cpu_req_t;

endpackage

// *** rtl/iam_evt_sync.sv ***
// Toggle synchroniser carrying a one-cycle event from one clock to another.
// Assumes events in the source domain are spaced well apart (many dest cycles).
module iam_evt_sync (
  // Source side
  input  wire logic src_clk,
  input  wire logic src_pulse,
  // Destination side
  input  wire logic dst_clk,
  output logic      dst_pulse,
  // Reset
  input  wire logic rst_b
);

  logic src_tgl_q;
  logic meta_q;
  logic sync_q;
  logic seen_q;

  always_ff @(posedge src_clk or negedge rst_b) begin
    if (!rst_b) src_tgl_q <= 1'b0;
    else        src_tgl_q <= src_tgl_q ^ src_pulse;
  end

  // Only sync_q and seen_q are looked at; meta_q feeds sync_q alone
  always_ff @(posedge dst_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      meta_q <= src_tgl_q;
      sync_q <= meta_q;
      seen_q <= sync_q;
    end
  end

  assign dst_pulse = sync_q ^ seen_q;

endmodule

// *** tb/iam_sva.sv ***
// Port-level checks on the status block, bound into iam_status.
// Assumes every flag and pin output is sampled on clk.
module iam_sva (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst_b,
  // Pins
  input wire logic                  serial_data_line_o,
  input wire logic                  serial_data_line_oe,
  // CPU and neighbours
  input wire iam_pkg::iam_cpu_req_t cpu_req,
  input wire logic [7:0]            bus_status_reg,
  input wire logic [7:0]            bus_control_reg,
  input wire logic                  master_mode,
  input wire logic                  start_generated,
  input wire logic                  arb_loss_evt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic dir = bus_status_reg[3];
  wire logic wr  = cpu_req.ctrl_wr;
  property p_od; serial_data_line_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data pin driven high");
  property p_rel; serial_data_line_oe |-> dir; endproperty
  a_rel: assert property (p_rel) else $error("data pin driven in receive");
  property p_ctl; wr |=> bus_control_reg == ($past(cpu_req.ctrl_wdata) & 8'h9f); endproperty
  a_ctl: assert property (p_ctl) else $error("control byte wrong");
  property p_exit; wr && cpu_req.ctrl_wdata[6] |=> !bus_status_reg[4] && !dir; endproperty
  a_exit: assert property (p_exit) else $error("exit left flags set");
  property p_en; wr && !cpu_req.ctrl_wdata[7] && bus_control_reg[7] |=> bus_status_reg[4:3] == 2'b00; endproperty
  a_en: assert property (p_en) else $error("disable left flags set");
  property p_wrel; wr && cpu_req.ctrl_wdata[5] && !start_generated |=> !dir; endproperty
  a_wrel: assert property (p_wrel) else $error("wait release kept direction");
  property p_arb;
    arb_loss_evt && bus_control_reg[7] && !bus_status_reg[6] && !start_generated |=> bus_status_reg[6] && !dir;
  endproperty
  a_arb: assert property (p_arb) else $error("arbitration loss handling wrong");
  property p_clr; (cpu_req.status_rd || cpu_req.bit_manip) && !arb_loss_evt |=> !bus_status_reg[6]; endproperty
  a_clr: assert property (p_clr) else $error("arbitration flag not cleared");
  property p_start;
    start_generated && master_mode && bus_control_reg[7] && !arb_loss_evt && !wr |=> dir;
  endproperty
  a_start: assert property (p_start) else $error("start did not set direction");
  property p_mset; $rose(bus_status_reg[4]) |-> bus_control_reg[7]; endproperty
  a_mset: assert property (p_mset) else $error("match set while disabled");
  c_match: cover property ($rose(bus_status_reg[4]));
  c_dir: cover property ($rose(dir));
  c_oe: cover property ($rose(serial_data_line_oe));
endmodule

bind iam_status iam_sva u_iam_sva (.clk(clk), .rst_b(rst_b), .serial_data_line_o(serial_data_line_o),
  .serial_data_line_oe(serial_data_line_oe), .cpu_req(cpu_req), .bus_status_reg(bus_status_reg),
  .bus_control_reg(bus_control_reg), .master_mode(master_mode), .start_generated(start_generated),
  .arb_loss_evt(arb_loss_evt));

// *** tb/iam_bus_model.sv ***
// Far-side bus master driving the clock and data wires, open drain.
// Assumes pull-ups on both wires; the device may pull data low.
module iam_bus_model (
  // Device pull-down
  input  wire logic dev_oe,
  // Wire levels
  output wire logic scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int H = 500;
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // Released wires float high, so clock stands still between frames
  assign scl = !scl_low;
  assign sda = !(sda_low || dev_oe);
  task automatic start();
    sda_low = 1'b0;
    #H scl_low = 1'b0;
    #H sda_low = 1'b1;
    #H scl_low = 1'b1;
    #H;
  endtask
  // Eight bits MSB first, then a released ninth clock
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_low = !b[i];
      #H scl_low = 1'b0;
      #H scl_low = 1'b1;
    end
    sda_low = 1'b0;
    #H scl_low = 1'b0;
    #H scl_low = 1'b1;
    #H;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #H scl_low = 1'b0;
    #H sda_low = 1'b0;
    #H;
  endtask
endmodule

// *** tb/i2c_addr_match_direction_status_bench.sv ***
// Self-checking bench for the address-match and direction status block.
// Assumes iam_bus_model as bus master and the bound checker.
module i2c_addr_match_direction_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0;
  logic                  mst = 1'b0, sgen = 1'b0, aloss = 1'b0, sol = 1'b0;
  logic [7:0]            st, ct;
  logic [7:0]            own_addr = 8'ha4;
  iam_pkg::iam_cpu_req_t req = '0;
  wire logic             scl, sda, oe;
  int                    fails = 0, n_checks = 0;
  always #5 clk = ~clk;
  always #32 link_clk = ~link_clk;
  iam_bus_model u_iam_bus_model (.dev_oe(oe), .scl(scl), .sda(sda));
  iam_status u_iam_status (.clk(clk), .rst_b(rst_b), .link_clk(link_clk), .serial_clock_line_i(scl),
    .serial_data_line_i(sda), .serial_data_line_o(), .serial_data_line_oe(oe), .cpu_req(req),
    .local_slave_address_reg(own_addr), .bus_status_reg(st), .bus_control_reg(ct), .master_mode(mst),
    .start_generated(sgen), .arb_loss_evt(aloss), .shift_output_latch(sol));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cpu(input logic [10:0] r, input logic g = 1'b0, input logic a = 1'b0);
    @(negedge clk);
    req = r;
    sgen = g;
    aloss = a;
    @(negedge clk);
    req = '0;
    sgen = 1'b0;
    aloss = 1'b0;
  endtask
  task automatic wr(input logic [7:0] v);
    cpu({1'b1, v, 2'b00});
  endtask
  task automatic flags(input logic [7:0] s, input logic o);
    repeat (3) @(negedge clk);
    chk(st, s);
    chk({7'h00, oe}, {7'h00, o});
  endtask
  task automatic addr(input logic [7:0] b);
    u_iam_bus_model.start();
    u_iam_bus_model.send(b);
  endtask
  task automatic t_slave_tx();
    wr(8'h80);
    chk(ct, 8'h80);
    addr(8'ha5);
    flags(8'h18, 1'b1);
    sol = 1'b1;
    flags(8'h18, 1'b0);
    wr(8'ha0);
    flags(8'h10, 1'b0);
    u_iam_bus_model.start();
    flags(8'h00, 1'b0);
    u_iam_bus_model.stop();
  endtask
  task automatic t_slave_rx();
    addr(8'ha4);
    flags(8'h10, 1'b0);
    u_iam_bus_model.stop();
    flags(8'h00, 1'b0);
    addr(8'h31);
    flags(8'h00, 1'b0);
    u_iam_bus_model.stop();
    own_addr = 8'h30;
    addr(8'h31);
    flags(8'h18, 1'b0);
    u_iam_bus_model.stop();
    flags(8'h00, 1'b0);
    own_addr = 8'ha4;
  endtask
  task automatic t_exit();
    addr(8'ha5);
    wr(8'hc0);
    flags(8'h00, 1'b0);
    chk(ct, 8'h80);
    u_iam_bus_model.stop();
    addr(8'ha5);
    wr(8'h00);
    flags(8'h00, 1'b0);
    u_iam_bus_model.stop();
    wr(8'h80);
  endtask
  task automatic t_master();
    mst = 1'b1;
    cpu(11'h000, 1'b1);
    flags(8'h08, 1'b0);
    addr(8'h41);
    flags(8'h00, 1'b0);
    addr(8'h40);
    flags(8'h08, 1'b0);
    u_iam_bus_model.stop();
    flags(8'h00, 1'b0);
    cpu(11'h000, 1'b1);
    cpu(11'h000, 1'b0, 1'b1);
    flags(8'h40, 1'b0);
    cpu(11'h001);
    flags(8'h00, 1'b0);
    cpu(11'h000, 1'b0, 1'b1);
    chk(st, 8'h40);
    cpu(11'h002);
    flags(8'h00, 1'b0);
    mst = 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #400us;
    fails++;
    final_report();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    flags(iam_pkg::STATUS_RESET, 1'b0);
    chk(ct, iam_pkg::CTRL_RESET);
    repeat (4) @(negedge link_clk);
    t_slave_tx();
    t_slave_rx();
    t_exit();
    t_master();
    final_report();
  end
endmodule
